// *** verilog/sbwm_map.vh ***
/*
  constants for the byte-lane write mask block: lane width, burst beat
  slots and memory geometry defaults.
  assumes inclusion by plain verilog-2005 design files only.
*/
`ifndef SBWM_MAP_VH
`define SBWM_MAP_VH

`define SBWM_LANE_BITS      9
`define SBWM_LANES_NARROW   2
`define SBWM_LANES_WIDE     4
`define SBWM_BURST_BEATS    4
`define SBWM_ADDR_BITS      6
`define SBWM_BEAT_BITS      2
`define SBWM_SEQ_IDLE       2'h0
`define SBWM_SEQ_BEAT01     2'h1
`define SBWM_SEQ_BEAT23     2'h2

`endif

// *** verilog/sbwm_lane_store.v ***
/*
  storage words with two write ports and one strobe per 9-bit lane.
  assumes strobes and data come from the same ref_clk domain.
*/
`timescale 1ns/1ns
`default_nettype none
module sbwm_lane_store #(
  parameter LANES = 4,
  parameter LBITS = 9,
  parameter DEPTH = 64,
  parameter AW    = 6
) (
  input  wire                   ref_clk,
  input  wire [AW-1:0]          wr_addr,
  input  wire [LANES-1:0]       lane_strobe,
  input  wire [LANES*LBITS-1:0] wr_data,
  input  wire [AW-1:0]          wr2_addr,
  input  wire [LANES-1:0]       lane_strobe2,
  input  wire [LANES*LBITS-1:0] wr2_data,
  input  wire [AW-1:0]          rd_addr,
  output reg  [LANES*LBITS-1:0] rd_data
);
  wire [LANES*LBITS-1:0] rd_word;
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1)
    begin : g_lane
      // one array per lane, so every lane has a single writer
      reg [LBITS-1:0] mem [0:DEPTH-1];
      // lanes without strobe keep old contents, no read-modify-write
      always @(posedge ref_clk)
      begin
        if (lane_strobe[g])
          mem[wr_addr] <= wr_data[g*LBITS +: LBITS];
        if (lane_strobe2[g])
          mem[wr2_addr] <= wr2_data[g*LBITS +: LBITS];
      end
      assign rd_word[g*LBITS +: LBITS] = mem[rd_addr];
    end
  endgenerate
  always @(posedge ref_clk)
  begin
    rd_data <= rd_word;
  end
endmodule // sbwm_lane_store
`default_nettype wire

// *** verilog/sbwm_write_mask.v ***
/*
  write port with byte-lane masking for a burst sram.
  assumes beats arrive as two pre-sampled half-beats per ref_clk: the
  positive-edge and the complementary-edge beat, each with its own mask.
  pins pass two flip-flops, so the whole sequence lags the pins by two.
*/
// Overview of operation
// - each beat carries its own sampled lane mask, applied only to it.
// - narrow mode with both selects low writes all eighteen bits.
// - narrow mode with only lane zero low writes bits 8:0 only.
// - narrow mode with only lane one low writes bits 17:9 only.
// - all selects high leaves the word unchanged for that beat.
// - wide mode with all four selects low writes all thirty-six bits.
// - wide selects zero to three gate bits 8:0, 17:9, 26:18 and 35:27.
// - wide mode with only lane zero low writes 8:0 and keeps 35:9.
// - masks outside a properly started write burst have no effect.
// - beats for A..A+3 come at pos t+1, comp t+1, pos t+2, comp t+2.
`timescale 1ns/1ns
`default_nettype none
`include "sbwm_map.vh"
module sbwm_write_mask #(
  parameter WIDE  = 1,
  parameter DEPTH = 64
) (
  input  wire                ref_clk,
  input  wire                reset,
  input  wire                write_port_select_n,
  input  wire [5:0]          wr_addr_pin,
  input  wire [35:0]         pos_data,
  input  wire [3:0]          pos_byte_lane_write_select_n,
  input  wire [35:0]         comp_data,
  input  wire [3:0]          comp_byte_lane_write_select_n,
  input  wire [5:0]          rd_addr,
  output reg  [35:0]         rd_data_q,
  output reg                 burst_busy_q
);
  localparam LB    = `SBWM_LANE_BITS;
  localparam LANES = WIDE ? `SBWM_LANES_WIDE : `SBWM_LANES_NARROW;
  localparam DW    = LANES * LB;
  localparam AW    = `SBWM_ADDR_BITS;

  // two-flop pin synchronisers; stage one is read by stage two only
  reg        wps_n_s1, wps_n_s2;
  reg [5:0]  addr_s1, addr_s2;
  reg [35:0] pd_s1, pd_s2, cd_s1, cd_s2;
  reg [3:0]  pm_s1, pm_s2, cm_s1, cm_s2;
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      wps_n_s1 <= 1'b1;
      wps_n_s2 <= 1'b1;
      addr_s1  <= 6'h00;
      addr_s2  <= 6'h00;
      pd_s1    <= 36'h0_0000_0000;
      pd_s2    <= 36'h0_0000_0000;
      cd_s1    <= 36'h0_0000_0000;
      cd_s2    <= 36'h0_0000_0000;
      pm_s1    <= 4'hf;
      pm_s2    <= 4'hf;
      cm_s1    <= 4'hf;
      cm_s2    <= 4'hf;
    end
    else
    begin
      wps_n_s1 <= write_port_select_n;
      wps_n_s2 <= wps_n_s1;
      addr_s1  <= wr_addr_pin;
      addr_s2  <= addr_s1;
      pd_s1    <= pos_data;
      pd_s2    <= pd_s1;
      cd_s1    <= comp_data;
      cd_s2    <= cd_s1;
      pm_s1    <= pos_byte_lane_write_select_n;
      pm_s2    <= pm_s1;
      cm_s1    <= comp_byte_lane_write_select_n;
      cm_s2    <= cm_s1;
    end
  end

  // active-low select to per-lane strobe; used for both beats
  function [3:0] lane_strobes;
    input [3:0] sel_n;
    input       active;
    begin
      lane_strobes = active ? ~sel_n : 4'h0;
    end
  endfunction

  reg [1:0]    seq_q, seq_d;
  reg [AW-1:0] base_q, base_d;
  reg          start_q;
  wire         req = ~wps_n_s2;

  // second request on the next rise is dropped: seq is not idle then
  always @*
  begin
    seq_d  = seq_q;
    base_d = base_q;
    case (seq_q)
      `SBWM_SEQ_IDLE:
      begin
        if (req & ~start_q)
        begin
          seq_d  = `SBWM_SEQ_BEAT01;
          base_d = addr_s2;
        end
      end
      `SBWM_SEQ_BEAT01: seq_d = `SBWM_SEQ_BEAT23;
      `SBWM_SEQ_BEAT23:
      begin
        seq_d = `SBWM_SEQ_IDLE;
        if (req & ~start_q)
        begin
          seq_d  = `SBWM_SEQ_BEAT01;
          base_d = addr_s2;
        end
      end
      default: seq_d = `SBWM_SEQ_IDLE;
    endcase
  end

  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      seq_q   <= `SBWM_SEQ_IDLE;
      base_q  <= {AW{1'b0}};
      start_q <= 1'b0;
    end
    else
    begin
      seq_q   <= seq_d;
      base_q  <= base_d;
      start_q <= (seq_d == `SBWM_SEQ_BEAT01) & (seq_q != `SBWM_SEQ_BEAT01);
    end
  end

  // beat offsets: pos edge gets even, comp edge odd address of the pair
  wire         in_burst = (seq_q == `SBWM_SEQ_BEAT01) |
                          (seq_q == `SBWM_SEQ_BEAT23);
  wire         hi_pair  = (seq_q == `SBWM_SEQ_BEAT23);
  wire [AW-1:0] pos_addr  = base_q + {{(AW-2){1'b0}}, hi_pair, 1'b0};
  wire [AW-1:0] comp_addr = base_q + {{(AW-2){1'b0}}, hi_pair, 1'b1};

  // unused lanes of the narrow option are masked off here
  wire [3:0] lane_ok  = WIDE ? 4'hf : 4'h3;
  wire [3:0] pos_stb  = lane_strobes(pm_s2, in_burst) & lane_ok;
  wire [3:0] comp_stb = lane_strobes(cm_s2, in_burst) & lane_ok;

  // both beats of a pair reach storage in the same cycle, one per port;
  // a shared port would lose one beat of every pair
  reg  [AW-1:0] pos_addr_q;
  reg  [AW-1:0] comp_addr_q;
  reg  [3:0]    pos_stb_q;
  reg  [3:0]    comp_stb_q;
  reg  [35:0]   pos_data_q;
  reg  [35:0]   comp_data_q;

  // strobes clear in reset so no stray write follows its release
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      pos_addr_q  <= {AW{1'b0}};
      pos_stb_q   <= 4'h0;
      pos_data_q  <= 36'h0_0000_0000;
      comp_addr_q <= {AW{1'b0}};
      comp_stb_q  <= 4'h0;
      comp_data_q <= 36'h0_0000_0000;
    end
    else
    begin
      pos_addr_q  <= pos_addr;
      pos_stb_q   <= pos_stb;
      pos_data_q  <= pd_s2;
      comp_addr_q <= comp_addr;
      comp_stb_q  <= comp_stb;
      comp_data_q <= cd_s2;
    end
  end
  // limitation: the extra stage delays storage by one cycle, which keeps
  // the address adder and mask decode off the memory write path

  wire [DW-1:0] rdw;
  sbwm_lane_store #(
    .LANES (LANES),
    .LBITS (LB),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_store (
    .ref_clk      (ref_clk),
    .wr_addr      (pos_addr_q),
    .lane_strobe  (pos_stb_q[LANES-1:0]),
    .wr_data      (pos_data_q[DW-1:0]),
    .wr2_addr     (comp_addr_q),
    .lane_strobe2 (comp_stb_q[LANES-1:0]),
    .wr2_data     (comp_data_q[DW-1:0]),
    .rd_addr      (rd_addr),
    .rd_data      (rdw)
  );

  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      rd_data_q    <= 36'h0_0000_0000;
      burst_busy_q <= 1'b0;
    end
    else
    begin
      rd_data_q    <= {{(36-DW){1'b0}}, rdw};
      burst_busy_q <= in_burst;
    end
  end
endmodule // sbwm_write_mask
`default_nettype wire

// *** tb/sbwm_chk.sv ***
/* port checker for the byte-lane write mask block.
   assumes a bind onto each instance of the top module. */
`timescale 1ns/1ns
`default_nettype none
module sbwm_chk #(
  parameter WIDE = 1
) (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        write_port_select_n,
  input wire logic [5:0]  rd_addr,
  input wire logic [35:0] rd_data_q,
  input wire logic        burst_busy_q
);
  logic [3:0] cnt_q;
  // age of last taken request; the rise right after one is not taken
  wire logic  acc = !write_port_select_n && cnt_q != 4'h1;
  always @(posedge ref_clk or posedge reset)
    cnt_q <= reset ? 4'h8 : acc ? 4'h1 : cnt_q + {3'h0, cnt_q != 4'hf};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_busy_after_req: assert property (
    acc |-> ##[2:5] burst_busy_q) else $error("busy missing");
  a_busy_rise_time: assert property (
    $rose(burst_busy_q) |-> cnt_q inside {[2:4]}) else $error("busy early");
  a_busy_two_beats: assert property (
    $rose(burst_busy_q) |=> burst_busy_q ##1 !burst_busy_q)
    else $error("busy length");
  a_busy_needs_req: assert property (
    burst_busy_q |-> cnt_q <= 4'h6) else $error("stray busy");
  a_word_quiet: assert property (
    cnt_q == 4'hf && $stable(rd_addr) && $past(rd_addr) == $past(rd_addr, 2)
    |=> $stable(rd_data_q)) else $error("word changed idle");
  a_word_window: assert property (
    !$stable(rd_data_q) && $stable(rd_addr) && $past(rd_addr, 3) == rd_addr
    && $past(rd_addr, 2) == rd_addr |-> cnt_q inside {[3:12]})
    else $error("word changed off time");
  a_narrow_top: assert property (
    WIDE == 0 |-> rd_data_q[35:18] == 18'h0) else $error("top bits set");
  a_reset_clear: assert property (
    $fell(reset) |-> !burst_busy_q && rd_data_q == 36'h0)
    else $error("not cleared");
endmodule // sbwm_chk
bind sbwm_write_mask sbwm_chk #(.WIDE(WIDE)) chk (.ref_clk, .reset,
  .write_port_select_n, .rd_addr, .rd_data_q, .burst_busy_q);
`default_nettype wire

// *** tb/sbwm_ctrl_model.sv ***
/* controller model on the write port of the byte-lane mask block.
   assumes calls start just after a rising edge of ref_clk. */
`timescale 1ns/1ns
`default_nettype none
module sbwm_ctrl_model (
  input  wire logic        ref_clk,
  output var  logic        write_port_select_n,
  output var  logic [5:0]  wr_addr_pin,
  output var  logic [35:0] pos_data,
  output var  logic [3:0]  pos_byte_lane_write_select_n,
  output var  logic [35:0] comp_data,
  output var  logic [3:0]  comp_byte_lane_write_select_n
);
  // idle lines toggle and lanes stay enabled, so any leak shows
  task automatic idle();
    write_port_select_n = 1'b1;
    wr_addr_pin = ~wr_addr_pin;
    pos_data = ~pos_data;
    comp_data = ~comp_data;
    pos_byte_lane_write_select_n = 4'h0;
    comp_byte_lane_write_select_n = 4'h0;
  endtask
  task automatic burst(input logic [5:0] a, input logic [143:0] d,
                       input logic [15:0] m, input logic dbl);
    write_port_select_n = 1'b0;
    wr_addr_pin = a;
    for (int b = 0; b < 2; b++)
    begin
      @(posedge ref_clk);
      #1;
      write_port_select_n = !(dbl && b == 0);
      wr_addr_pin = a ^ 6'h20;
      {comp_data, pos_data} = d[72*b +: 72];
      pos_byte_lane_write_select_n = m[8*b +: 4];
      comp_byte_lane_write_select_n = m[8*b+4 +: 4];
    end
    @(posedge ref_clk);
    #1;
    idle();
  endtask
  initial
  begin
    {wr_addr_pin, pos_data, comp_data} = '0;
    idle();
  end
endmodule // sbwm_ctrl_model
`default_nettype wire

// *** tb/sbwm_write_mask_bench.sv ***
/* self-checking bench for the byte-lane write mask, both widths.
   assumes the controller model and the bound checker are compiled. */
`timescale 1ns/1ns
`default_nettype none
module sbwm_write_mask_bench;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        write_port_select_n;
  logic [5:0]  wr_addr_pin;
  logic [5:0]  rd_addr = 6'h00;
  logic [35:0] pos_data, comp_data, ow, on;
  logic [3:0]  pos_byte_lane_write_select_n, comp_byte_lane_write_select_n;
  logic [35:0] ew [64];
  logic [35:0] en [64];
  logic [31:0] lf = 32'h0000_0006;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;
  sbwm_ctrl_model ctl (.ref_clk, .write_port_select_n, .wr_addr_pin,
    .pos_data, .pos_byte_lane_write_select_n, .comp_data,
    .comp_byte_lane_write_select_n);
  sbwm_write_mask #(.WIDE(1)) uut (.ref_clk, .reset, .write_port_select_n,
    .wr_addr_pin, .pos_data, .pos_byte_lane_write_select_n, .comp_data,
    .comp_byte_lane_write_select_n, .rd_addr, .rd_data_q(ow),
    .burst_busy_q());
  sbwm_write_mask #(.WIDE(0)) uut_narrow (.ref_clk, .reset,
    .write_port_select_n, .wr_addr_pin, .pos_data,
    .pos_byte_lane_write_select_n, .comp_data,
    .comp_byte_lane_write_select_n, .rd_addr, .rd_data_q(on),
    .burst_busy_q());
  always #20 ref_clk = ~ref_clk;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge ref_clk)
    if (++cyc == 8000)
    begin
      err_total++;
      finish_test();
    end
  function automatic logic [35:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return {lf[3:0], lf};
  endfunction
  // low select writes its lane, high keeps the old lane
  function automatic logic [35:0] mrg(logic [35:0] o, n, logic [3:0] m);
    for (int g = 0; g < 4; g++)
      if (!m[g])
        o[9*g +: 9] = n[9*g +: 9];
    return o;
  endfunction
  task automatic cmp(input string nm, input logic [35:0] e, s);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
    ctl.idle();
  endtask
  // also reads the block a second request would hit, to see it ignored
  task automatic run(input logic [5:0] a, input logic [15:0] m,
                     input logic dbl, input int nrd);
    logic [143:0] d;
    d = {rnd(), rnd(), rnd(), rnd()};
    for (int b = 0; b < 4; b++)
    begin
      ew[a + 6'(b)] = mrg(ew[a + 6'(b)], d[36*b +: 36], m[4*b +: 4]);
      en[a + 6'(b)] = mrg(en[a + 6'(b)], d[36*b +: 18], m[4*b +: 4] | 4'hc);
    end
    @(posedge ref_clk);
    #1;
    ctl.burst(a, d, m, dbl);
    repeat (4) tick();
    for (int k = 0; k < nrd; k++)
    begin
      rd_addr = a ^ 6'(k % 4 + k / 4 * 32);
      repeat (3) tick();
      cmp("wide word", ew[rd_addr], ow);
      cmp("narrow word", en[rd_addr], on);
    end
  endtask
  initial
  begin
    foreach (en[i])
      en[i] = 36'h0;
    repeat (4) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    // storage powers up unknown: fill every word before any read
    for (int i = 0; i < 16; i++)
      run(6'(i * 4), 16'h0, 1'b0, 0);
    for (int i = 0; i < 32; i++)
      run(6'(i * 4), i < 16 ? 16'h0 : {4{4'(i)}}, 1'b0, 8);
    for (int i = 0; i < 40; i++)
      run({lf[9:6], 2'h0}, lf[31:16], i % 8 == 0, 8);
    finish_test();
  end
endmodule // sbwm_write_mask_bench
`default_nettype wire
